// ### rtl/pbs_pkg.sv
// package: constants and types for the pipelined burst sram port
package pbs_pkg;
  localparam int ADDR_W      = 17;   // 128k words in the 36-bit configuration
  localparam int DATA_W      = 36;   // four lanes of 8 data + 1 parity
  localparam int LANES       = 4;
  localparam int LANE_W      = 9;
  localparam int DEPTH       = 16;   // modelled storage words, indexed by low address bits
  localparam int IDX_W       = 4;
  localparam int BURST_W     = 2;
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic [3:0] STROBE_RST = 4'hf;

  // operation class of a pipeline slot; gray along idle->read->write
  typedef enum logic [1:0] {
    PBS_OP_IDLE  = 2'h0,
    PBS_OP_READ  = 2'h1,
    PBS_OP_WRITE = 2'h3
  } pbs_op_t;
endpackage

// ### rtl/pbs_burst_counter.sv
// file: 2-bit burst address counter, interleaved or linear
`timescale 1ns/10ps
module pbs_burst_counter (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              hold,
  input  wire logic              load,
  input  wire logic              advance,
  input  wire logic              burst_order_select,
  input  wire logic [1:0]        start_bits,
  output logic      [1:0]        burst_bits
);
  import pbs_pkg::*;

  logic [1:0] start_q, start_d;
  logic [1:0] count_q, count_d;

  // next start value and count; the counter wraps freely through four steps
  always_comb begin
    start_d = start_q;
    count_d = count_q;
    if (!hold) begin
      if (load) begin
        start_d = start_bits;
        count_d = BURST_RST;
      end else if (advance) begin
        count_d = count_q + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_q <= BURST_RST;
      count_q <= BURST_RST;
    end else begin
      start_q <= start_d;
      count_q <= count_d;
    end
  end

  // an advance addresses the next step, so the first word after a load is start op 1;
  // using count_q itself would repeat the loaded word once
  logic [1:0] step;
  assign step = count_q + 2'h1;

  // xor gives the interleaved walk, add gives the linear one
  assign burst_bits = burst_order_select ? (start_q ^ step)
                                         : (start_q + step);
endmodule

// ### rtl/pbs_sram_port.sv
// file: command decode, data pipeline and storage of the burst sram port
// Summary of operation
// - load address, read/write data two cycles later
// - advance high during a burst: bump counter, use internal address; with no burst running it is a noop
// - bursts keep direction captured at load
// - selected only when all three selects true
// - deselect tristates bus two cycles later
// - hold high freezes every register and data_out; output enable still gates data_oe
// - outputs float after first clock edge
// - active-low lane strobes, byte plus parity
// - any strobe mix; only chosen lanes written
// - narrow configuration has only lanes 1,2
// - order pin high: interleaved xor sequence
// - order pin low: linear add sequence
// - counter wraps after fourth address
`timescale 1ns/10ps
module pbs_sram_port (
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        cycle_hold_n,
  input  wire logic                        select_low_a_n,
  input  wire logic                        select_low_b_n,
  input  wire logic                        select_high,
  input  wire logic                        advance_or_load,
  input  wire logic                        read_not_write,
  input  wire logic                        output_enable_n,
  input  wire logic                        burst_order_select,
  input  wire logic                        narrow_mode,
  input  wire logic [pbs_pkg::ADDR_W-1:0]  addr,
  input  wire logic [pbs_pkg::LANES-1:0]   byte_lane_strobe_n,
  input  wire logic [pbs_pkg::DATA_W-1:0]  data_in,
  output logic      [pbs_pkg::DATA_W-1:0]  data_out,
  output logic      [pbs_pkg::DATA_W-1:0]  data_oe
);
  import pbs_pkg::*;

  // the cycle_hold_n pin is active high hold despite its name suffix kept from the map
  logic hold;
  logic selected;
  logic load_cmd;
  logic burst_cmd;
  logic [1:0] burst_bits;

  assign hold      = cycle_hold_n;
  assign selected  = !select_low_a_n && !select_low_b_n && select_high;
  assign load_cmd  = !advance_or_load && selected;

  // pipeline stage 1 (address/control taken) and stage 2 (data cycle)
  // timing of one transfer, counting the edge that takes the command as edge 0:
  //   edge 0: command decoded into stage 1 (op1_q, a1_q)
  //   edge 1: stage 1 moves to stage 2 (op2_q, a2_q)
  //   edge 2: a read word is registered onto the pins, a write word is
  //           taken from data_in together with its lane strobes
  // so reads and writes share one data cycle position and the bus turns
  // around without idle slots; a write slot never launches read data.
  // a write followed at once by a read of the same word reads the new
  // contents, since the write lands at the edge before the read samples.
  // hold blocks the whole edge, so every stage keeps its contents.
  pbs_op_t                 op1_q, op1_d, op2_q, op2_d;
  logic [ADDR_W-1:0]       base_q, base_d;
  logic [ADDR_W-1:0]       a1_q, a1_d, a2_q, a2_d;
  logic [LANES-1:0]        s1_q, s1_d;
  pbs_op_t                 dir_q, dir_d;  // direction of the running burst
  logic [DATA_W-1:0]       rd_q, rd_d;
  logic                    rd_en_q, rd_en_d;
  logic [DATA_W-1:0]       mem_q [DEPTH];
  logic [DATA_W-1:0]       mem_d [DEPTH];

  // a burst continues only from a read/write slot; else it is a noop
  assign burst_cmd = advance_or_load && (dir_q != PBS_OP_IDLE);

  pbs_burst_counter u_burst (
    .ref_clk            (ref_clk),
    .sys_rst            (sys_rst),
    .hold               (hold),
    .load               (load_cmd),
    .advance            (burst_cmd),
    .burst_order_select (burst_order_select),
    .start_bits         (addr[1:0]),
    .burst_bits         (burst_bits)
  );

  // lane enable from active-low strobes, upper lanes absent when narrow
  function automatic logic [LANES-1:0] lane_en(input logic [LANES-1:0] s_n,
                                               input logic narrow);
    logic [LANES-1:0] e;
    e = ~s_n;
    if (narrow) begin
      e[3:2] = 2'h0;
    end
    return e;
  endfunction

  // merge write data lane by lane
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                              input logic [DATA_W-1:0] new_w,
                                              input logic [LANES-1:0] en);
    logic [DATA_W-1:0] r;
    r = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (en[i]) begin
        r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction

  // index of the modelled storage word
  function automatic logic [IDX_W-1:0] idx(input logic [ADDR_W-1:0] a);
    return a[IDX_W-1:0];
  endfunction

  // command decode and pipeline advance; hold freezes everything
  always_comb begin
    op1_d   = op1_q;
    op2_d   = op2_q;
    base_d  = base_q;
    a1_d    = a1_q;
    a2_d    = a2_q;
    s1_d    = s1_q;
    dir_d   = dir_q;
    rd_d    = rd_q;
    rd_en_d = rd_en_q;
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (!hold) begin
      op2_d = op1_q;
      a2_d  = a1_q;
      if (load_cmd) begin
        dir_d  = read_not_write ? PBS_OP_READ : PBS_OP_WRITE;
        base_d = addr;
        op1_d  = dir_d;
        a1_d   = addr;
        s1_d   = byte_lane_strobe_n;
      end else if (burst_cmd) begin
        op1_d  = dir_q;
        a1_d   = {base_q[ADDR_W-1:2], burst_bits};
        s1_d   = byte_lane_strobe_n;
      end else begin
        // deselect or noop: pending slots drain, new slot idle
        dir_d = (advance_or_load) ? dir_q : PBS_OP_IDLE;
        op1_d = PBS_OP_IDLE;
        s1_d  = STROBE_RST;
      end
      // write data and strobes arrive in the data cycle, two edges after the load
      if (op2_q == PBS_OP_WRITE) begin
        mem_d[idx(a2_q)] = merge(mem_q[idx(a2_q)], data_in,
                                 lane_en(byte_lane_strobe_n, narrow_mode));
      end
      // read data registered for the data cycle, two edges after the load
      rd_en_d = (op2_q == PBS_OP_READ);
      if (op2_q == PBS_OP_READ) begin
        rd_d = mem_q[idx(a2_q)];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op1_q   <= PBS_OP_IDLE;
      op2_q   <= PBS_OP_IDLE;
      base_q  <= '0;
      a1_q    <= '0;
      a2_q    <= '0;
      s1_q    <= STROBE_RST;
      dir_q   <= PBS_OP_IDLE;
      rd_q    <= '0;
      rd_en_q <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      op1_q   <= op1_d;
      op2_q   <= op2_d;
      base_q  <= base_d;
      a1_q    <= a1_d;
      a2_q    <= a2_d;
      s1_q    <= s1_d;
      dir_q   <= dir_d;
      rd_q    <= rd_d;
      rd_en_q <= rd_en_d;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  // output enable gating stays combinational: it is the pin's asynchronous control
  assign data_out = rd_q;
  assign data_oe  = (rd_en_q && !output_enable_n) ? '1 : '0;

  // checks: each one looks only at what this block drives or stores;
  // multi-cycle antecedents demand an unheld edge, or a held one in the hold checks, so a suspend never fakes a failure
  read_lat_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && load_cmd && read_not_write) ##1 !hold ##1 !hold |=> rd_en_q)
    else $error("read data not enabled two cycles after load");
  hold_frz_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    hold |=> $stable(rd_q) && $stable(rd_en_q) && $stable(op1_q))
    else $error("hold did not freeze the pipeline");
  desel_z_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && !advance_or_load && !selected) ##1 (!hold && !load_cmd && !burst_cmd)
      ##1 !hold |=> !rd_en_q)
    else $error("bus driven after deselect");
  noop_z_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && advance_or_load && dir_q == PBS_OP_IDLE) |=> op1_q == PBS_OP_IDLE)
    else $error("advance after idle was not a noop");
  dir_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && burst_cmd) |=> op1_q == $past(dir_q))
    else $error("burst changed direction");
  sel_dec_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (select_low_a_n || select_low_b_n || !select_high) |-> !load_cmd)
    else $error("load taken while deselected");
  oe_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    output_enable_n |-> data_oe == '0)
    else $error("bus driven with output enable high");
  burst_int_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && burst_cmd) |=> a1_q[ADDR_W-1:2] == $past(base_q[ADDR_W-1:2]))
    else $error("burst left its base address");
  load_adr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && load_cmd) |=> a1_q == $past(addr)
      && op1_q == ($past(read_not_write) ? PBS_OP_READ : PBS_OP_WRITE))
    else $error("load did not take address and direction");
  slot_move_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !hold |=> op2_q == $past(op1_q) && a2_q == $past(a1_q))
    else $error("stage 1 did not move to stage 2");
  rd_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && op2_q == PBS_OP_READ) |=> rd_en_q && rd_q == $past(mem_q[idx(a2_q)]))
    else $error("read word not launched in its data cycle");
  rd_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && op2_q != PBS_OP_READ) |=> !rd_en_q)
    else $error("bus enabled without a read slot");
  desel_drop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && !advance_or_load && !selected) |=> op1_q == PBS_OP_IDLE && dir_q == PBS_OP_IDLE)
    else $error("deselect opened a slot");
  sel_ok_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!select_low_a_n && !select_low_b_n && select_high && !advance_or_load) |-> load_cmd)
    else $error("load refused while selected");
  dir_wr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && burst_cmd && dir_q == PBS_OP_WRITE) |=> op1_q == PBS_OP_WRITE)
    else $error("write burst turned into a read");
  noop_stay_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && advance_or_load && dir_q == PBS_OP_IDLE) |=> dir_q == PBS_OP_IDLE)
    else $error("noop started a burst");
  wr_full_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && op2_q == PBS_OP_WRITE && byte_lane_strobe_n == 4'h0 && !narrow_mode)
      |=> mem_q[$past(idx(a2_q))] == $past(data_in))
    else $error("full write did not store the word");
  wr_none_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && op2_q == PBS_OP_WRITE && byte_lane_strobe_n == 4'hf)
      |=> mem_q[$past(idx(a2_q))] == $past(mem_q[idx(a2_q)]))
    else $error("write with no strobes changed storage");
  lane_one_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && op2_q == PBS_OP_WRITE && byte_lane_strobe_n == 4'he)
      |=> mem_q[$past(idx(a2_q))][LANE_W-1:0] == $past(data_in[LANE_W-1:0])
        && mem_q[$past(idx(a2_q))][DATA_W-1:LANE_W] == $past(mem_q[idx(a2_q)][DATA_W-1:LANE_W]))
    else $error("lane 1 write touched the wrong bits");
  lane_top_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && op2_q == PBS_OP_WRITE && byte_lane_strobe_n == 4'h7 && !narrow_mode)
      |=> mem_q[$past(idx(a2_q))][DATA_W-1:3*LANE_W] == $past(data_in[DATA_W-1:3*LANE_W])
        && mem_q[$past(idx(a2_q))][3*LANE_W-1:0] == $past(mem_q[idx(a2_q)][3*LANE_W-1:0]))
    else $error("lane 4 write touched the wrong bits");
  narrow_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && op2_q == PBS_OP_WRITE && narrow_mode)
      |=> mem_q[$past(idx(a2_q))][DATA_W-1:2*LANE_W] == $past(mem_q[idx(a2_q)][DATA_W-1:2*LANE_W]))
    else $error("narrow write reached an absent lane");
  hold_state_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    hold |=> $stable(a1_q) && $stable(op2_q) && $stable(dir_q) && $stable(base_q))
    else $error("hold let the address pipeline move");
  hold_mem_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    hold |=> mem_q[$past(idx(a2_q))] == $past(mem_q[idx(a2_q)]))
    else $error("hold let a write land");
  wrap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && load_cmd) ##1 (!hold && burst_cmd) [*4] |=> a1_q == $past(a1_q, 4))
    else $error("burst did not wrap to its first address");
  ilv_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && load_cmd) ##1 (!hold && burst_cmd && burst_order_select)
      |=> a1_q[1:0] == ($past(a1_q[1:0]) ^ 2'h1))
    else $error("interleaved step wrong");
  lin_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!hold && load_cmd) ##1 (!hold && burst_cmd && !burst_order_select)
      |=> a1_q[1:0] == 2'($past(a1_q[1:0]) + 2'h1))
    else $error("linear step wrong");
  oe_on_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rd_en_q && !output_enable_n) |-> data_oe == '1)
    else $error("read data not driven with output enable low");
  rd_cov_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    load_cmd && read_not_write ##1 burst_cmd ##1 burst_cmd);
  wr_cov_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    load_cmd && !read_not_write ##1 load_cmd && read_not_write);
  hold_cov_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    rd_en_q && hold);
  narrow_cov_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    !hold && op2_q == PBS_OP_WRITE && narrow_mode);
  desel_cov_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    load_cmd ##1 (!advance_or_load && !selected));
endmodule

// ### test/pbs_ctl_model.sv
// file: memory controller model driving command, address and write data
`timescale 1ns/10ps
module pbs_ctl_model (
  input  wire logic                      ref_clk,
  output logic                           cycle_hold_n,
  output logic                           select_low_a_n,
  output logic                           select_low_b_n,
  output logic                           select_high,
  output logic                           advance_or_load,
  output logic                           read_not_write,
  output logic [pbs_pkg::ADDR_W-1:0]     addr,
  output logic [pbs_pkg::LANES-1:0]      byte_lane_strobe_n,
  output logic [pbs_pkg::DATA_W-1:0]     data_in
);
  import pbs_pkg::*;
  // start deselected with no data on the bus
  initial begin
    {cycle_hold_n, advance_or_load, read_not_write} = 3'h0;
    {select_low_a_n, select_low_b_n, select_high} = 3'h6;
    addr = '0;
    byte_lane_strobe_n = 4'hf;
    data_in = '0;
  end
  // one bus cycle, changed only just after a rising edge
  task automatic cyc(input logic h, input logic adv, input logic rnw, input logic [2:0] sel,
                     input logic [ADDR_W-1:0] a, input logic dv,
                     input logic [DATA_W-1:0] d, input logic [LANES-1:0] s_n);
    @(posedge ref_clk);
    cycle_hold_n <= h;
    advance_or_load <= adv;
    read_not_write <= rnw;
    {select_low_a_n, select_low_b_n, select_high} <= sel;
    addr <= a;
    // released data shows the inverse so stale words never match
    data_in <= dv ? d : ~data_in;
    byte_lane_strobe_n <= s_n;
  endtask
endmodule

// ### test/pipelined_burst_sram_port_bench.sv
// file: self-checking bench for the burst sram port
`timescale 1ns/10ps
module pipelined_burst_sram_port_bench;
  import pbs_pkg::*;
  localparam logic [2:0] SEL_ON = 3'h1;
  logic                ref_clk, sys_rst, output_enable_n, burst_order_select, narrow_mode;
  logic                hold, sel_a_n, sel_b_n, sel_h, adv, rnw;
  logic [ADDR_W-1:0]   addr;
  logic [LANES-1:0]    strb_n;
  logic [DATA_W-1:0]   data_in, data_out, data_oe;
  logic [DATA_W-1:0]   exp_mem [DEPTH];
  int                  failures, n_compared;

  pbs_ctl_model ctl (.ref_clk(ref_clk), .cycle_hold_n(hold), .select_low_a_n(sel_a_n),
    .select_low_b_n(sel_b_n), .select_high(sel_h), .advance_or_load(adv),
    .read_not_write(rnw), .addr(addr), .byte_lane_strobe_n(strb_n), .data_in(data_in));
  pbs_sram_port uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cycle_hold_n(hold),
    .select_low_a_n(sel_a_n), .select_low_b_n(sel_b_n), .select_high(sel_h),
    .advance_or_load(adv), .read_not_write(rnw), .output_enable_n(output_enable_n),
    .burst_order_select(burst_order_select), .narrow_mode(narrow_mode), .addr(addr),
    .byte_lane_strobe_n(strb_n), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk36(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // burst address: low two bits xor or add the count, wrapping mod four
  function automatic logic [3:0] waddr(input logic [3:0] a, input logic ord, input int k);
    return {a[3:2], ord ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
  endfunction

  // load, n-1 advances with the direction pin inverted, deselect, noop, idle
  task automatic burst(input logic wr, input logic [3:0] a, input logic ord, input int n,
                       input logic [3:0] s_n, input logic [2:0] dsel);
    int k;
    logic [3:0] wa;
    logic [DATA_W-1:0] d;
    @(posedge ref_clk) burst_order_select <= ord;
    for (int i = 0; i <= n + 4; i++) begin
      k = wr ? i - 2 : i - 3;
      wa = waddr(a, ord, k);
      d = 36'h9a5c3e17f ^ {4{9'(i * 37 + a)}};
      if (wr && k >= 0 && k < n)
        for (int j = 0; j < LANES; j++)
          if (!s_n[j] && !(narrow_mode && j >= 2)) exp_mem[wa][LANE_W*j +: LANE_W] = d[LANE_W*j +: LANE_W];
      ctl.cyc(1'b0, (i > 0 && i < n) || i == n + 1, (i == 0) ? !wr : wr,
              (i == 0) ? SEL_ON : dsel, ADDR_W'(a), wr && k >= 0 && k < n, d, s_n);
      #1;
      if (!wr && k >= 0 && k < n) begin
        chk36(data_out, exp_mem[wa]);
        chk36(data_oe, '1);
      end else
        chk36(data_oe, '0);
    end
  endtask

  // full writes fill storage, then both burst orders read back past the wrap
  task automatic t_order();
    for (int b = 0; b < 4; b++)
      burst(1'b1, 4'(b * 4), 1'b0, 4, 4'h0, 3'h0);
    burst(1'b0, 4'h1, 1'b1, 6, 4'h0, 3'h5);
    burst(1'b0, 4'h6, 1'b0, 5, 4'h0, 3'h3);
    burst(1'b1, 4'h9, 1'b1, 2, 4'h0, 3'h0);
    burst(1'b0, 4'h8, 1'b0, 4, 4'h0, 3'h7);
    $display("test order done");
  endtask

  // single-lane strobes, none, mixed, then narrow mode with every strobe low
  task automatic t_lanes();
    logic [3:0] mix [6] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hf, 4'ha};
    foreach (mix[m]) burst(1'b1, 4'(m + 2), 1'b0, 1, mix[m], 3'h0);
    @(posedge ref_clk) narrow_mode <= 1'b1;
    burst(1'b1, 4'h4, 1'b0, 4, 4'h0, 3'h0);
    @(posedge ref_clk) narrow_mode <= 1'b0;
    burst(1'b0, 4'h0, 1'b0, 4, 4'h0, 3'h0);
    burst(1'b0, 4'h4, 1'b1, 4, 4'h0, 3'h0);
    $display("test lanes done");
  endtask

  // hold freezes a read word on the pins; output enable floats it meanwhile
  task automatic t_hold();
    ctl.cyc(1'b0, 1'b0, 1'b1, SEL_ON, ADDR_W'(6), 1'b0, '0, 4'hf);
    repeat (2) ctl.cyc(1'b0, 1'b0, 1'b0, 3'h0, '0, 1'b0, '0, 4'hf);
    for (int i = 3; i < 7; i++) begin
      ctl.cyc(i < 6, 1'b0, 1'b0, 3'h0, '0, 1'b0, '0, 4'hf);
      output_enable_n <= (i == 5);
      #1;
      chk36(data_out, exp_mem[6]);
      chk36(data_oe, (i == 5) ? '0 : '1);
    end
    ctl.cyc(1'b0, 1'b0, 1'b0, 3'h0, '0, 1'b0, '0, 4'hf);
    #1;
    chk36(data_oe, '0);
    $display("test hold done");
  endtask

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // runs take well under a thousand cycles, so this only trips on a hang
  initial begin
    #20000;
    failures++;
    close_out();
  end

  initial begin
    {sys_rst, output_enable_n, burst_order_select, narrow_mode} = 4'h8;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk36(data_oe, '0);
    t_order();
    t_lanes();
    t_hold();
    close_out();
  end
endmodule
